// file: rtl/wdr_pkg.sv
// wdr_pkg: register map, field layout, reset values and timing for the watchdog and reset control block.
// assumes a 250 MHz system clock and a slow oscillator enable derived from it.
package wdr_pkg;
    localparam int unsigned sys_clk_hz = 250000000;
    localparam int unsigned slow_oscillator_frequency = 32000;
    localparam int unsigned slow_div_cycles = sys_clk_hz / slow_oscillator_frequency;
    localparam int unsigned slow_div_width = 14;
    localparam int unsigned software_reset_delay_ns = 1000;
    localparam int unsigned software_reset_delay_cycles = (software_reset_delay_ns * 250 + 999) / 1000;
    localparam int unsigned pin_reset_delay_ns = 1000;
    localparam int unsigned pin_reset_delay_cycles = (pin_reset_delay_ns * 250 + 999) / 1000;
    localparam int unsigned delay_width = 16;

    localparam logic [11:0] watchdog_control_addr = 12'h000;
    localparam logic [11:0] reset_cause_flags_addr = 12'h004;
    localparam logic [11:0] reset_pin_function_key_addr = 12'h008;
    localparam logic [11:0] status_addr = 12'h00C;

    localparam logic [7:0] watchdog_control_reset = 8'h53;
    localparam logic [7:0] reset_pin_function_key_reset = 8'h55;
    localparam logic [4:0] key_disable = 5'h15;
    localparam logic [4:0] key_enable = 5'h0A;
    localparam logic [7:0] pin_key_io = 8'h55;
    localparam logic [7:0] pin_key_reset = 8'hAA;

    localparam int unsigned key_lsb = 3;
    localparam int unsigned key_msb = 7;
    localparam int unsigned sel_msb = 2;
    localparam int unsigned flag_wdt_key = 0;
    localparam int unsigned flag_lv_key = 1;
    localparam int unsigned flag_lv = 2;
    localparam int unsigned flag_rst_key = 3;
    localparam int unsigned flag_count = 4;
    localparam int unsigned stat_timeout = 0;
    localparam int unsigned stat_power_down = 1;
    localparam int unsigned wdt_width = 18;

    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    typedef enum logic [1:0] {wdr_run_type_s, wdr_hold_type_s, wdr_delay_type_s} wdr_rst_state_type;
endpackage

// file: rtl/wdr_delay.sv
// wdr_delay: fixed-length countdown, one pulse when it expires.
// assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ns
`default_nettype none
module wdr_delay
#(
    parameter int unsigned cycles = 1
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    output logic busy,
    output logic done
);
    import wdr_pkg::*;
    logic [delay_width-1:0] cnt_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                cnt_q <= delay_width'(cycles);
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (cnt_q <= delay_width'(1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_q <= cnt_q - delay_width'(1);
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/wdr_top.sv
// wdr_top: watchdog timer, reset cause flags and keyed reset pin function, AXI4-Lite slave.
// assumes the core pulses clear/halt inputs for one cycle and acts on the reset outputs.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module wdr_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic clear_watchdog_instruction,
    input wire logic halt_instruction,
    input wire logic standby_mode,
    input wire logic low_voltage_fault,
    input wire logic low_voltage_key_fault,
    input wire logic external_reset_pin,
    output logic device_reset,
    output logic pc_sp_reset,
    output logic pin_is_reset_input,
    output logic watchdog_enabled
);
    import wdr_pkg::*;

    logic [7:0] wdt_ctrl_q;
    logic [7:0] pin_key_q;
    logic [flag_count-1:0] flags_q;
    logic timeout_q;
    logic power_down_q;
    logic [slow_div_width-1:0] slow_div_q;
    logic slow_tick_q;
    logic [wdt_width-1:0] wdt_q;
    logic overflow_q;
    logic wdt_key_bad_q;
    logic pin_key_bad_q;
    logic wdt_fault_start;
    logic pin_fault_start;
    logic wdt_fault_busy;
    logic pin_fault_busy;
    logic wdt_fault_done;
    logic pin_fault_done;
    logic pin_rel_busy;
    logic pin_rel_done;
    logic pin_low;
    logic pin_low_q;
    logic key_reset_q;
    logic [wdt_width-1:0] terminal;
    logic wr_fire;
    logic aw_hold_q;
    logic w_hold_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_mapped;
    logic wr_lane0;
    logic [31:0] rd_word;
    logic rd_mapped;
    wdr_rst_state_type rst_state_q;

    always_comb
    begin
        case (wdt_ctrl_q[sel_msb:0])
            3'h0: terminal = wdt_width'(18'h000FF);
            3'h1: terminal = wdt_width'(18'h003FF);
            3'h2: terminal = wdt_width'(18'h00FFF);
            3'h3: terminal = wdt_width'(18'h03FFF);
            3'h4: terminal = wdt_width'(18'h07FFF);
            3'h5: terminal = wdt_width'(18'h0FFFF);
            3'h6: terminal = wdt_width'(18'h1FFFF);
            default: terminal = wdt_width'(18'h3FFFF);
        endcase
    end

    // write channel capture, address and data in either order
    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign wr_lane0 = wstrb_q[0];
    assign wr_mapped = awaddr_q == watchdog_control_addr || awaddr_q == reset_cause_flags_addr
        || awaddr_q == reset_pin_function_key_addr || awaddr_q == status_addr;
    assign pin_low = pin_is_reset_input && !external_reset_pin;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end
        else
        begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? resp_okay : resp_slverr;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel
    always_comb
    begin
        rd_word = '0;
        rd_mapped = 1'b1;
        case (s_axi_araddr)
            watchdog_control_addr: rd_word[7:0] = wdt_ctrl_q;
            reset_cause_flags_addr: rd_word[flag_count-1:0] = flags_q;
            reset_pin_function_key_addr: rd_word[7:0] = pin_key_q;
            status_addr:
            begin
                rd_word[stat_timeout] = timeout_q;
                rd_word[stat_power_down] = power_down_q;
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= resp_okay;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_mapped ? resp_okay : resp_slverr;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wdt_ctrl_q <= watchdog_control_reset;
            pin_key_q <= reset_pin_function_key_reset;
        end
        else if (device_reset)
        begin
            // pin key survives overflow and pin resets, else a held pin would deselect itself
            wdt_ctrl_q <= watchdog_control_reset;
            if (key_reset_q)
                pin_key_q <= reset_pin_function_key_reset;
        end
        else if (wr_fire && wr_lane0)
        begin
            if (awaddr_q == watchdog_control_addr)
                wdt_ctrl_q <= wdata_q[7:0];
            if (awaddr_q == reset_pin_function_key_addr)
                pin_key_q <= wdata_q[7:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            watchdog_enabled <= 1'b1;
            pin_is_reset_input <= 1'b0;
            wdt_key_bad_q <= 1'b0;
            pin_key_bad_q <= 1'b0;
        end
        else
        begin
            watchdog_enabled <= wdt_ctrl_q[key_msb:key_lsb] == key_enable;
            pin_is_reset_input <= pin_key_q == pin_key_reset;
            // held off during reset so a stale bad value cannot restart a fault delay
            wdt_key_bad_q <= wdt_ctrl_q[key_msb:key_lsb] != key_enable
                && wdt_ctrl_q[key_msb:key_lsb] != key_disable && !device_reset;
            pin_key_bad_q <= pin_key_q != pin_key_io && pin_key_q != pin_key_reset && !device_reset;
        end
    end

    // fault delays start once per bad value
    assign wdt_fault_start = wdt_key_bad_q && !wdt_fault_busy && !wdt_fault_done && !device_reset;
    assign pin_fault_start = pin_key_bad_q && !pin_fault_busy && !pin_fault_done && !device_reset;

    wdr_delay #(.cycles(software_reset_delay_cycles)) u_wdt_fault
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(wdt_fault_start),
        .busy(wdt_fault_busy),
        .done(wdt_fault_done)
    );

    wdr_delay #(.cycles(software_reset_delay_cycles)) u_pin_fault
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(pin_fault_start),
        .busy(pin_fault_busy),
        .done(pin_fault_done)
    );

    wdr_delay #(.cycles(pin_reset_delay_cycles)) u_pin_release
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(pin_low_q && !pin_low),
        .busy(pin_rel_busy),
        .done(pin_rel_done)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            slow_div_q <= '0;
            slow_tick_q <= 1'b0;
        end
        else
        begin
            slow_tick_q <= slow_div_q == slow_div_width'(slow_div_cycles - 1);
            if (slow_div_q == slow_div_width'(slow_div_cycles - 1))
                slow_div_q <= '0;
            else
                slow_div_q <= slow_div_q + slow_div_width'(1);
        end
    end

    // clear and halt instructions both restart count in software
    // halt clears, then counts if enabled
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wdt_q <= '0;
            overflow_q <= 1'b0;
        end
        else
        begin
            overflow_q <= 1'b0;
            if (wdt_key_bad_q || clear_watchdog_instruction || halt_instruction || pin_low || device_reset)
                wdt_q <= '0;
            else if (watchdog_enabled && slow_tick_q)
            begin
                if (wdt_q >= terminal)
                begin
                    wdt_q <= '0;
                    overflow_q <= 1'b1;
                end
                else
                    wdt_q <= wdt_q + wdt_width'(1);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timeout_q <= 1'b0;
            power_down_q <= 1'b0;
        end
        else if (overflow_q)
        begin
            timeout_q <= 1'b1;
            if (standby_mode)
                power_down_q <= 1'b1;
        end
        else if (halt_instruction)
        begin
            timeout_q <= 1'b0;
            power_down_q <= 1'b1;
        end
        else if (clear_watchdog_instruction)
        begin
            timeout_q <= 1'b0;
            power_down_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags_q <= '0;
        else
        begin
            for (int i = 0; i < flag_count; i++)
            begin
                if (wr_fire && wr_lane0 && awaddr_q == reset_cause_flags_addr && !wdata_q[i])
                    flags_q[i] <= 1'b0;
            end
            if (wdt_fault_done)
                flags_q[flag_wdt_key] <= 1'b1;
            if (pin_fault_done)
                flags_q[flag_rst_key] <= 1'b1;
            if (low_voltage_fault)
                flags_q[flag_lv] <= 1'b1;
            if (low_voltage_key_fault)
                flags_q[flag_lv_key] <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_low_q <= 1'b0;
            key_reset_q <= 1'b0;
            rst_state_q <= wdr_hold_type_s;
            device_reset <= 1'b1;
            pc_sp_reset <= 1'b1;
        end
        else
        begin
            pin_low_q <= pin_low;
            key_reset_q <= 1'b0;
            device_reset <= 1'b0;
            pc_sp_reset <= 1'b0;
            case (rst_state_q)
                wdr_run_type_s:
                begin
                    if (pin_low)
                        rst_state_q <= wdr_hold_type_s;
                    else if (wdt_fault_done || pin_fault_done || (overflow_q && !standby_mode))
                    begin
                        device_reset <= 1'b1;
                        pc_sp_reset <= 1'b1;
                        key_reset_q <= wdt_fault_done || pin_fault_done;
                    end
                    else if (overflow_q)
                        pc_sp_reset <= 1'b1;
                end
                wdr_hold_type_s:
                begin
                    device_reset <= 1'b1;
                    pc_sp_reset <= 1'b1;
                    if (!pin_low)
                        rst_state_q <= pin_low_q ? wdr_delay_type_s : wdr_run_type_s;
                end
                wdr_delay_type_s:
                begin
                    device_reset <= 1'b1;
                    pc_sp_reset <= 1'b1;
                    if (pin_low)
                        rst_state_q <= wdr_hold_type_s;
                    else if (pin_rel_done || !pin_rel_busy)
                        rst_state_q <= wdr_run_type_s;
                end
                default: rst_state_q <= wdr_run_type_s;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: testbench/wdr_core_model.sv
// wdr_core_model: stand-in processor core that issues clear and halt instructions.
// assumes the bench calls its tasks just after a rising edge of aclk.
`timescale 1ns/1ns
`default_nettype none
module wdr_core_model
(
    input wire logic aclk,
    output logic clear_watchdog_instruction,
    output logic halt_instruction,
    output logic standby_mode
);
    initial
    begin
        clear_watchdog_instruction = 1'b0;
        halt_instruction = 1'b0;
        standby_mode = 1'b0;
    end
    task automatic clear_wdt();
    begin
        standby_mode <= 1'b0;
        clear_watchdog_instruction <= 1'b1;
        @(posedge aclk);
        clear_watchdog_instruction <= 1'b0;
    end
    endtask
    // one-cycle pulse; core then sits in standby until cleared
    task automatic enter_halt();
    begin
        halt_instruction <= 1'b1;
        standby_mode <= 1'b1;
        @(posedge aclk);
        halt_instruction <= 1'b0;
    end
    endtask
endmodule
`default_nettype wire

// file: testbench/wdr_top_sva.sv
// wdr_top_sva: port-level checks for wdr_top.
// assumes one clock aclk and synchronous active-low aresetn.
`timescale 1ns/1ns
`default_nettype none
module wdr_top_sva
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic external_reset_pin,
    input wire logic device_reset,
    input wire logic pc_sp_reset,
    input wire logic pin_is_reset_input,
    input wire logic watchdog_enabled
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_reset_defaults: assert property ($rose(aresetn) |->
        device_reset && pc_sp_reset && watchdog_enabled && !pin_is_reset_input ##1 device_reset ##1 !device_reset)
        else $error("reset values wrong or reset not released");
    a_pcsp_with_dev: assert property (device_reset |-> pc_sp_reset)
        else $error("device reset without pc/sp reset");
    a_pin_holds: assert property (pin_is_reset_input && !external_reset_pin |-> ##[1:2] device_reset)
        else $error("low reset pin did not hold device in reset");
    a_pin_delay: assert property ($rose(external_reset_pin) && $past(pin_is_reset_input) && device_reset
        |=> device_reset [*8])
        else $error("reset dropped without delay after pin release");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("second write response");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("second read response");
    a_read_answer: assert property ($rose(s_axi_arvalid) |=> s_axi_arready && s_axi_rvalid)
        else $error("read not answered in one cycle");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read data not zero");

    c_dev_reset: cover property ($rose(device_reset));
    c_pin_reset: cover property (pin_is_reset_input && !external_reset_pin);
    c_disabled: cover property (!watchdog_enabled);
endmodule
bind wdr_top wdr_top_sva i_wdr_top_sva (.*);
`default_nettype wire

// file: testbench/test_watchdog_and_reset_control.sv
// test_watchdog_and_reset_control: self-checking bench for wdr_top over AXI4-Lite.
// assumes wdr_pkg timing; overflow counts run millions of cycles, so no overflow here.
`timescale 1ns/1ns
`default_nettype none
module test_watchdog_and_reset_control;
    import wdr_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} wdr_exp_type;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, external_reset_pin = 1'b1;
    logic low_voltage_fault = 1'b0, low_voltage_key_fault = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic clear_watchdog_instruction, halt_instruction, standby_mode;
    logic device_reset, pc_sp_reset, pin_is_reset_input, watchdog_enabled;
    int error_cnt = 0, comparisons = 0, seed = 57;
    wdr_exp_type exp_q[$];
    wdr_exp_type e;

    always #2 aclk = ~aclk;

    wdr_top i_wdr_top (.*);
    wdr_core_model i_wdr_core_model (.aclk(aclk), .clear_watchdog_instruction(clear_watchdog_instruction),
        .halt_instruction(halt_instruction), .standby_mode(standby_mode));

    task automatic fail(input string s);
    begin
        error_cnt++;
        $display("unexpected at %0t: %s", $time, s);
    end
    endtask
    task automatic chk(input logic c, input string s);
    begin
        comparisons++;
        if (c !== 1'b1)
            fail(s);
    end
    endtask
    task automatic test_done();
    begin
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        bit aw;
        bit w;
    begin
        exp_q.push_back('{32'h00000000, 32'h00000000, r});
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($random(seed)), d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1)
            @(posedge aclk);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    end
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m, input logic [1:0] r);
    begin
        exp_q.push_back('{{24'h000000, d}, {(m != 8'h00) ? 24'hFFFFFF : 24'h000000, m}, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1)
            @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1)
            @(posedge aclk);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    end
    endtask
    task automatic until_dev(input logic v, output int n);
    begin
        n = 0;
        while (device_reset !== v && n < 1000)
        begin
            @(posedge aclk);
            n++;
        end
    end
    endtask

    // responses checked against the oldest note
    always @(posedge aclk)
    begin
        if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
        begin
            comparisons++;
            if (exp_q.size() == 0)
                fail("response with nothing expected");
            else
            begin
                e = exp_q.pop_front();
                if (s_axi_rvalid === 1'b1 && ((((s_axi_rdata ^ e.d) & e.m) !== 32'h00000000) || s_axi_rresp !== e.r))
                    fail("read data or response");
                else if (s_axi_rvalid !== 1'b1 && s_axi_bresp !== e.r)
                    fail("write response");
            end
        end
    end

    initial
    begin
        int n;
        logic [4:0] k;
        logic [7:0] p;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(watchdog_control_addr, watchdog_control_reset, 8'hFF, resp_okay);
        rd(reset_pin_function_key_addr, reset_pin_function_key_reset, 8'hFF, resp_okay);
        rd(reset_cause_flags_addr, 8'h00, 8'hFB, resp_okay);
        rd(status_addr, 8'h00, 8'h03, resp_okay);
        rd(12'h010, 8'h00, 8'h00, resp_slverr);
        wr(12'h010, 8'hFF, resp_slverr);
        for (int s = 0; s < 8; s++)
        begin
            wr(watchdog_control_addr, {key_disable, 3'(s)}, resp_okay);
            rd(watchdog_control_addr, {key_disable, 3'(s)}, 8'hFF, resp_okay);
        end
        chk(watchdog_enabled === 1'b0, "watchdog not disabled");
        wr(watchdog_control_addr, {key_enable, 3'b011}, resp_okay);
        repeat (2) @(posedge aclk);
        chk(watchdog_enabled === 1'b1, "watchdog not enabled");
        k = 5'($random(seed));
        while (k == key_enable || k == key_disable)
            k = 5'($random(seed));
        wr(watchdog_control_addr, {k, 3'b000}, resp_okay);
        until_dev(1'b1, n);
        chk(n + 4 >= software_reset_delay_cycles && n <= software_reset_delay_cycles + 8, "key fault delay");
        until_dev(1'b0, n);
        rd(reset_cause_flags_addr, 8'h01, 8'hFB, resp_okay);
        rd(watchdog_control_addr, watchdog_control_reset, 8'hFF, resp_okay);
        wr(reset_cause_flags_addr, 8'hFF, resp_okay);
        rd(reset_cause_flags_addr, 8'h01, 8'hFB, resp_okay);
        wr(reset_cause_flags_addr, 8'h00, resp_okay);
        rd(reset_cause_flags_addr, 8'h00, 8'hFB, resp_okay);
        low_voltage_fault <= 1'b1;
        low_voltage_key_fault <= 1'b1;
        @(posedge aclk);
        low_voltage_fault <= 1'b0;
        low_voltage_key_fault <= 1'b0;
        rd(reset_cause_flags_addr, 8'h06, 8'hFF, resp_okay);
        wr(reset_cause_flags_addr, 8'h00, resp_okay);
        wr(reset_pin_function_key_addr, pin_key_reset, resp_okay);
        repeat (2) @(posedge aclk);
        chk(pin_is_reset_input === 1'b1, "pin not reset input");
        external_reset_pin <= 1'b0;
        repeat (20) @(posedge aclk);
        chk(device_reset === 1'b1 && pc_sp_reset === 1'b1, "pin low not held");
        external_reset_pin <= 1'b1;
        until_dev(1'b0, n);
        chk(n + 4 >= pin_reset_delay_cycles && n < 1000, "pin release delay");
        wr(reset_pin_function_key_addr, pin_key_io, resp_okay);
        external_reset_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(pin_is_reset_input === 1'b0 && device_reset === 1'b0, "pin as io reset");
        external_reset_pin <= 1'b1;
        p = 8'($random(seed));
        while (p == pin_key_io || p == pin_key_reset)
            p = 8'($random(seed));
        wr(reset_pin_function_key_addr, p, resp_okay);
        until_dev(1'b1, n);
        chk(n < 1000, "pin key fault no reset");
        until_dev(1'b0, n);
        rd(reset_cause_flags_addr, 8'h08, 8'hFB, resp_okay);
        rd(reset_pin_function_key_addr, pin_key_io, 8'hFF, resp_okay);
        s_axi_wstrb <= 4'hE;
        wr(watchdog_control_addr, 8'h00, resp_okay);
        s_axi_wstrb <= 4'hF;
        rd(watchdog_control_addr, watchdog_control_reset, 8'hFF, resp_okay);
        i_wdr_core_model.enter_halt();
        repeat (2) @(posedge aclk);
        rd(status_addr, 8'h02, 8'h03, resp_okay);
        i_wdr_core_model.clear_wdt();
        repeat (2) @(posedge aclk);
        rd(status_addr, 8'h00, 8'h03, resp_okay);
        test_done();
    end

    // whole run is about a thousand cycles, well inside the 20000-cycle limit
    initial
    begin
        #(4 * 20000);
        fail("run did not finish");
        test_done();
    end
endmodule
`default_nettype wire
